//--- design/rct_edge_det.sv
// Synchroniser and edge detector for the external trigger pin.
// Assumes the pin is asynchronous to ref_clk_in.
`timescale 1ns/1ps
module rct_edge_det (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic pin_in,
  rct_edge_if.src edge_if
);
  logic sync1_q;
  logic sync1_d;
  logic sync2_q;
  logic sync2_d;
  logic prev_q;
  logic prev_d;
  logic [1:0] fill_q;
  logic [1:0] fill_d;
  logic primed;

  always_comb begin
    sync1_d = sync1_q;
    sync2_d = sync2_q;
    prev_d = prev_q;
    fill_d = fill_q;
    if (clk_en_in) begin
      sync1_d = pin_in;
      sync2_d = sync1_q;
      prev_d = sync2_q;
      if (fill_q != 2'h3) begin
        fill_d = fill_q + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      fill_q <= fill_d;
    end
  end

  // Edges count only once the chain holds real pin samples, so a pin idling high
  // gives no false edge right after reset
  assign primed = fill_q == 2'h3;

  // One event per transition, seen in the cycle the synchronised level changes
  assign edge_if.level = sync2_q;
  assign edge_if.rise = clk_en_in & primed & sync2_q & ~prev_q;
  assign edge_if.fall = clk_en_in & primed & ~sync2_q & prev_q;
endmodule

//--- design/rct_timer.sv
// Sixteen-bit reload/capture timer: auto-reload with optional up/down, or capture.
// Assumes a free-running ref_clk_in and an asynchronous external trigger pin.
//
// Operation
// - 16-bit count with two modes, auto-reload and single-channel capture.
// - Without prescaler the count advances once every twelve clocks.
// - Counting continues while run enable is set, never stops itself.
// - Up-only reload mode counts up from reload value, overflows after ffff.
// - Up-only reload also optionally triggered by a selected pin edge.
// - Up-counting reload value comes from the reload/capture register.
// - Up-only reload mode raises interrupt on every reload.
// - With up/down enabled in reload mode the pin level selects count direction.
// - Up/down enabled in reload mode never raises an interrupt.
// - Counting down reloads ffff after reaching the reload/capture value.
// - Down-count reload comes only from underflow, never a pin edge.
// - Capture mode counts up from zero and reloads zero on overflow.
// - Capture mode copies count into reload/capture register on selected edge.
// - Capture mode interrupts on both reload and capture.
`timescale 1ns/1ps
`include "rct_cfg.svh"
module rct_timer #(
  parameter int CNT_W = `RCT_CNT_W
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic run_in,
  input wire logic capture_mode_in,
  input wire logic updown_en_in,
  input wire logic prescaler_off_in,
  input wire logic edge_reload_en_in,
  input wire logic edge_rising_in,
  input wire logic ext_trigger_pin_in,
  input wire logic reload_wr_in,
  input wire logic [CNT_W-1:0] reload_data_in,
  input wire logic count_wr_in,
  input wire logic [CNT_W-1:0] count_data_in,
  input wire logic irq_clear_in,
  output logic [CNT_W-1:0] timer_count_reg_out,
  output logic [CNT_W-1:0] reload_capture_reg_out,
  output logic irq_out,
  output logic reload_flag_out,
  output logic capture_flag_out,
  output logic count_down_out
);
  localparam logic [CNT_W-1:0] ONES = CNT_W'(`RCT_ALL_ONES);
  localparam logic [CNT_W-1:0] ZERO = CNT_W'(`RCT_ZERO);

  rct_edge_if trig_if ();

  rct_edge_det rct_edge_det_inst (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .pin_in(ext_trigger_pin_in),
    .edge_if(trig_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: a tick every twelfth clock; with the prescaler on, every clock

  logic [`RCT_DIV_W-1:0] div_q;
  logic [`RCT_DIV_W-1:0] div_d;
  logic tick;

  always_comb begin
    div_d = div_q;
    tick = 1'b0;
    if (clk_en_in && run_in) begin
      if (!prescaler_off_in) begin
        tick = 1'b1;
        div_d = '0;
      end else if (div_q == `RCT_DIV_LAST) begin
        tick = 1'b1;
        div_d = '0;
      end else begin
        div_d = div_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count, reload/capture register and events

  rct_pkg::rct_mode_t mode;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] rc_q;
  logic [CNT_W-1:0] rc_d;
  logic down;
  logic sel_edge;
  logic reload_ev;
  logic capture_ev;

  assign mode = capture_mode_in ? rct_pkg::RCT_MODE_CAPTURE : rct_pkg::RCT_MODE_RELOAD;
  assign down = updown_en_in && !trig_if.level;
  assign sel_edge = edge_rising_in ? trig_if.rise : trig_if.fall;

  always_comb begin
    cnt_d = cnt_q;
    rc_d = rc_q;
    reload_ev = 1'b0;
    capture_ev = 1'b0;
    case (mode)
      rct_pkg::RCT_MODE_CAPTURE: begin
        if (run_in && sel_edge) begin
          rc_d = cnt_q;
          capture_ev = 1'b1;
        end
        if (tick) begin
          if (cnt_q == ONES) begin
            cnt_d = ZERO;
            reload_ev = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      rct_pkg::RCT_MODE_RELOAD: begin
        if (down) begin
          if (tick) begin
            if (cnt_q == rc_q) begin
              cnt_d = ONES;
              reload_ev = 1'b1;
            end else begin
              cnt_d = cnt_q - 1'b1;
            end
          end
        end else if (run_in && !updown_en_in && edge_reload_en_in && sel_edge) begin
          cnt_d = rc_q;
          reload_ev = 1'b1;
        end else if (tick) begin
          if (cnt_q == ONES) begin
            cnt_d = rc_q;
            reload_ev = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      default: begin
        cnt_d = cnt_q;
      end
    endcase
    if (!clk_en_in) begin
      cnt_d = cnt_q;
      rc_d = rc_q;
      reload_ev = 1'b0;
      capture_ev = 1'b0;
    end else begin
      // Software writes lose to an event in the same cycle: a reload/capture write to a capture, so no sample is dropped, and a count write to a reload
      if (reload_wr_in && !capture_ev) begin
        rc_d = reload_data_in;
      end
      if (count_wr_in && !reload_ev) begin
        cnt_d = count_data_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cnt_q <= CNT_W'(`RCT_CNT_RESET);
      rc_q <= CNT_W'(`RCT_RC_RESET);
    end else begin
      cnt_q <= cnt_d;
      rc_q <= rc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags and the registered count direction; a new event wins over a clear in the same cycle

  logic irq_q;
  logic irq_d;
  logic rel_q;
  logic rel_d;
  logic cap_q;
  logic cap_d;
  logic dir_q;
  logic dir_d;
  logic irq_ev;

  // Up/down operation suppresses interrupts entirely
  assign irq_ev = (reload_ev || capture_ev) && !(mode == rct_pkg::RCT_MODE_RELOAD &&
                  updown_en_in);

  always_comb begin
    irq_d = irq_q;
    rel_d = rel_q;
    cap_d = cap_q;
    dir_d = dir_q;
    if (clk_en_in) begin
      dir_d = down && (mode == rct_pkg::RCT_MODE_RELOAD);
      if (irq_clear_in) begin
        irq_d = 1'b0;
        rel_d = 1'b0;
        cap_d = 1'b0;
      end
      if (irq_ev) begin
        irq_d = 1'b1;
      end
      if (reload_ev) begin
        rel_d = 1'b1;
      end
      if (capture_ev) begin
        cap_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      irq_q <= 1'b0;
      rel_q <= 1'b0;
      cap_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      rel_q <= rel_d;
      cap_q <= cap_d;
      dir_q <= dir_d;
    end
  end

  assign timer_count_reg_out = cnt_q;
  assign reload_capture_reg_out = rc_q;
  assign irq_out = irq_q;
  assign reload_flag_out = rel_q;
  assign capture_flag_out = cap_q;
  assign count_down_out = dir_q;
endmodule

//--- dv/rct_pin_model.sv
// Board logic behind the external trigger pin.
// Moves the pin a few ns after the call, unrelated to the timer clock.
`timescale 1ns/1ps
module rct_pin_model (
  output logic pin_out
);
  initial pin_out = 1'b0;
  task automatic drive(input logic lvl);
    #3 pin_out = lvl;
  endtask
endmodule

//--- dv/rct_timer_bench.sv
// Self-checking bench for rct_timer with the pin model.
// Needs rct_timer_properties compiled alongside; clock enable is driven by the bench.
`timescale 1ns/1ps
module rct_timer_bench;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, cap = 1'b0, ud = 1'b0, pre = 1'b0;
  logic erl = 1'b0, ris = 1'b1, rw = 1'b0, cw = 1'b0, clr = 1'b0, en = 1'b1, pin;
  logic [15:0] rd = 16'h0, cd = 16'h0, cnt, rc;
  logic irq, rf, cf, dn;
  int mismatches = 0;
  int num_checks = 0;
  int i;
  always #5 clk = ~clk;
  rct_pin_model rct_pin_model_inst (.pin_out(pin));
  rct_timer rct_timer_inst (.ref_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(en),
    .run_in(run), .capture_mode_in(cap), .updown_en_in(ud), .prescaler_off_in(pre),
    .edge_reload_en_in(erl), .edge_rising_in(ris), .ext_trigger_pin_in(pin),
    .reload_wr_in(rw), .reload_data_in(rd), .count_wr_in(cw), .count_data_in(cd),
    .irq_clear_in(clr), .timer_count_reg_out(cnt), .reload_capture_reg_out(rc),
    .irq_out(irq), .reload_flag_out(rf), .capture_flag_out(cf), .count_down_out(dn));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] c, input logic [15:0] r);
    cd = c;
    rd = r;
    cw = 1'b1;
    rw = 1'b1;
    cyc(1);
    cw = 1'b0;
    rw = 1'b0;
  endtask
  task automatic irq_clr();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_prescale();
    pre = 1'b1;
    wr(16'h0010, 16'hfff0);
    run = 1'b1;
    cyc(11);
    chk(cnt, 16'h0010);
    cyc(1);
    chk(cnt, 16'h0011);
    cyc(12);
    chk(cnt, 16'h0012);
  endtask
  task automatic t_reload();
    pre = 1'b0;
    irq_clr();
    wr(16'hfffe, 16'hfff0);
    cyc(2);
    chk(cnt, 16'hfff0);
    chk(16'(irq), 16'h0001);
    // A low clock enable must freeze the running count
    en = 1'b0;
    cyc(3);
    chk(cnt, 16'hfff0);
    en = 1'b1;
  endtask
  task automatic t_edge();
    erl = 1'b1;
    wr(16'h1000, 16'hfff0);
    irq_clr();
    rct_pin_model_inst.drive(1'b1);
    cyc(5);
    chk(16'(rf), 16'h0001);
    chk(cnt, 16'hfff2);
    wr(16'h1000, 16'hfff0);
    irq_clr();
    rct_pin_model_inst.drive(1'b0);
    cyc(5);
    chk(16'(rf), 16'h0000);
    erl = 1'b0;
  endtask
  task automatic t_updown();
    ud = 1'b1;
    irq_clr();
    wr(16'h0014, 16'h0010);
    cyc(5);
    chk(cnt, 16'hffff);
    chk(16'(dn), 16'h0001);
    chk(16'(irq), 16'h0000);
    ud = 1'b0;
  endtask
  task automatic t_capture();
    cap = 1'b1;
    ris = 1'b0;
    // The count sits at ffff here; a count write would lose to that wrap, so let it pass
    cyc(1);
    wr(16'hffff, 16'h0000);
    cyc(1);
    chk(cnt, 16'h0000);
    chk(16'(irq), 16'h0001);
    pre = 1'b1;
    irq_clr();
    rct_pin_model_inst.drive(1'b1);
    cyc(4);
    chk(16'(cf), 16'h0000);
    wr(16'h1234, 16'h0000);
    for (i = 0; i < 20 && cnt === 16'h1234; i++) cyc(1);
    if (i == 20) begin
      mismatches++;
      return;
    end
    rct_pin_model_inst.drive(1'b0);
    cyc(4);
    chk(rc, 16'h1235);
    chk(16'(cf & irq), 16'h0001);
  endtask
  initial begin
    cyc(6);
    rst_n = 1'b1;
    t_prescale();
    t_reload();
    t_edge();
    t_updown();
    t_capture();
    tally_and_finish();
  end
endmodule
bind rct_timer rct_timer_properties rct_timer_properties_inst (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .run_in(run_in),
  .capture_mode_in(capture_mode_in), .updown_en_in(updown_en_in),
  .prescaler_off_in(prescaler_off_in), .edge_reload_en_in(edge_reload_en_in),
  .ext_trigger_pin_in(ext_trigger_pin_in), .reload_wr_in(reload_wr_in),
  .count_wr_in(count_wr_in), .irq_clear_in(irq_clear_in),
  .timer_count_reg_out(timer_count_reg_out), .reload_capture_reg_out(reload_capture_reg_out),
  .irq_out(irq_out), .reload_flag_out(reload_flag_out),
  .capture_flag_out(capture_flag_out), .count_down_out(count_down_out));

//--- dv/rct_timer_properties.sv
// Port-level assertions for the reload/capture timer.
// Bound to rct_timer by the bench; expects clk_en_in mostly high.
`timescale 1ns/1ps
module rct_timer_properties (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic run_in,
  input wire logic capture_mode_in,
  input wire logic updown_en_in,
  input wire logic prescaler_off_in,
  input wire logic edge_reload_en_in,
  input wire logic ext_trigger_pin_in,
  input wire logic reload_wr_in,
  input wire logic count_wr_in,
  input wire logic irq_clear_in,
  input wire logic [15:0] timer_count_reg_out,
  input wire logic [15:0] reload_capture_reg_out,
  input wire logic irq_out,
  input wire logic reload_flag_out,
  input wire logic capture_flag_out,
  input wire logic count_down_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Only checked with a tick every clock; the divided rate is left to the bench
  wire logic step = clk_en_in && run_in && !prescaler_off_in && !count_wr_in;
  wire logic up_only = !capture_mode_in && !updown_en_in;
  wire logic top = timer_count_reg_out == 16'hffff;
  irq_sticky_a: assert property (irq_out && !irq_clear_in |=> irq_out)
    else $error("irq dropped");
  up_step_a: assert property (step && up_only && !edge_reload_en_in && !top
    |=> timer_count_reg_out == $past(timer_count_reg_out) + 16'h0001) else $error("no step");
  up_reload_a: assert property (step && up_only && !reload_wr_in && top
    |=> timer_count_reg_out == $past(reload_capture_reg_out)) else $error("bad reload");
  reload_irq_a: assert property (step && up_only && top |=> irq_out && reload_flag_out)
    else $error("no reload irq");
  updown_quiet_a: assert property (updown_en_in && !capture_mode_in && !irq_out |=> !irq_out)
    else $error("updown irq");
  // Direction follows the pin as sampled two edges back, as the synchroniser sees it
  down_wrap_a: assert property (step && updown_en_in && !capture_mode_in
    && !$past(ext_trigger_pin_in, 2) && timer_count_reg_out == reload_capture_reg_out
    |=> top) else $error("no down wrap");
  dir_low_a: assert property ((updown_en_in && !capture_mode_in && run_in && clk_en_in
    && !ext_trigger_pin_in)[*3] |=> count_down_out) else $error("not down");
  cap_wrap_a: assert property (step && capture_mode_in && top |=> timer_count_reg_out == 16'h0)
    else $error("no zero wrap");
  cap_value_a: assert property ($rose(capture_flag_out) |-> irq_out &&
    reload_capture_reg_out == $past(timer_count_reg_out)) else $error("bad capture");
  cover property ($rose(capture_flag_out));
  cover property (count_down_out && top);
  cover property ($rose(reload_flag_out) && !capture_mode_in);
endmodule

//--- pkg/rct_cfg.svh
// Constants of the reload/capture timer: counts, fixed reload values, reset values.
// Included by the rct_timer design module only; holds definitions only.
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH
`define RCT_CNT_W 16
`define RCT_PCLK_DIV 12
`define RCT_DIV_W 4
`define RCT_ALL_ONES 16'hffff
`define RCT_ZERO 16'h0000
`define RCT_CNT_RESET 16'h0000
`define RCT_RC_RESET 16'h0000
`define RCT_DIV_LAST 4'hb
`endif

//--- pkg/rct_edge_if.sv
// Interface carrying the synchronised trigger pin level and its edge events.
// Driven by the edge detector, read by the timer core on the same clock.
`timescale 1ns/1ps
interface rct_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

//--- pkg/rct_pkg.sv
// Types shared by the reload/capture timer modules.
// Assumes rct_cfg.svh is on the include path.
package rct_pkg;
  typedef enum logic [1:0] {
    RCT_MODE_RELOAD = 2'h1,
    RCT_MODE_CAPTURE = 2'h2
  } rct_mode_t;
endpackage
